// [hdl/mah_pkg.sv]
package mah_pkg;
    // Frame constants
    localparam logic [7:0] START_BYTE = 8'h02;
    localparam logic [15:0] FRAME_TYPE = 16'h0002;
    localparam logic [7:0] CMD_CPL = 8'h01;
    localparam logic [7:0] CMD_START = 8'h02;
    localparam logic [7:0] CMD_INQ = 8'h03;
    localparam logic [7:0] RSP_CPL = 8'h81;
    localparam logic [7:0] RSP_START = 8'h82;
    localparam logic [7:0] RSP_INQ = 8'h83;
    localparam logic [15:0] LEN_RESULT = 16'h0002;
    localparam logic [15:0] LEN_OBJ_ID = 16'h0001;
    localparam logic [15:0] RES_OK = 16'h0000;
    localparam logic [15:0] RES_NET_DOWN = 16'h0001;
    localparam logic [15:0] RES_INVALID = 16'h0011;
    localparam logic [7:0] FN_NOT_IMPL = 8'h00;
    localparam logic [7:0] FIRST_OBJ_ID = 8'h01;
    localparam logic [7:0] OBJ_COUNT_ONE = 8'h01;
    localparam logic [7:0] FCC_INIT = 8'h00;
    // Per-object answer: result, count, id pair, class, length, inquiry data
    localparam int INQ_DATA_MIN = 194;
    localparam logic [15:0] RSP_INQ_MIN_LEN = 16'(2 + 1 + 2 + 3 + 2 + INQ_DATA_MIN);
    // Transmit byte positions
    localparam logic [3:0] TX_IDX_STX = 4'h0;
    localparam logic [3:0] TX_IDX_FT_HI = 4'h1;
    localparam logic [3:0] TX_IDX_FT_LO = 4'h2;
    localparam logic [3:0] TX_IDX_CN = 4'h3;
    localparam logic [3:0] TX_IDX_FN = 4'h4;
    localparam logic [3:0] TX_IDX_DL_HI = 4'h5;
    localparam logic [3:0] TX_IDX_DL_LO = 4'h6;
    localparam logic [3:0] TX_IDX_PAY0 = 4'h7;
    // Receive positions
    localparam logic [15:0] RX_HDR_LAST = 16'h0005;
    localparam logic [15:0] RX_PAY_KEEP = 16'h0005;
    localparam int RX_HDR_BYTES = 6;
    localparam int RX_PAY_BYTES = 5;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_INQ_SEND = 4'h1, S_INQ_WAIT = 4'h2, S_WAIT_INFO = 4'h3,
        S_CPL_SEND = 4'h4, S_CPL_WAIT = 4'h5, S_BUILD = 4'h6, S_START_SEND = 4'h7,
        S_START_WAIT = 4'h8, S_NORMAL = 4'h9, S_ERROR = 4'ha
    } mah_seq_t;

    typedef enum logic [1:0] {
        R_IDLE = 2'h0, R_HDR = 2'h1, R_PAY = 2'h2, R_FCC = 2'h3
    } mah_rx_t;

    // Running check code over frame_type through payload
    function automatic logic [7:0] mah_fcc_step(input logic [7:0] acc, input logic [7:0] b);
        return acc ^ b;
    endfunction
endpackage

// [hdl/mah_rx_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface mah_rx_if;
    logic frame_ok;
    logic frame_bad;
    logic [15:0] frame_type;
    logic [7:0] command_code;
    logic [7:0] function_byte;
    logic [15:0] payload_length;
    logic [15:0] result;
    logic [7:0] obj_count;
    logic [7:0] obj_num;
    logic [7:0] obj_total;
    modport rx (output frame_ok, frame_bad, frame_type, command_code, function_byte,
        payload_length, result, obj_count, obj_num, obj_total);
    modport seq (input frame_ok, frame_bad, frame_type, command_code, function_byte,
        payload_length, result, obj_count, obj_num, obj_total);
endinterface
`default_nettype wire

// [hdl/mah_rx_frame.sv]
`timescale 1ns/1ps
`default_nettype none
module mah_rx_frame (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    mah_rx_if.rx fr
);
    import mah_pkg::*;

    mah_rx_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d;
    logic [7:0] fcc_q, fcc_d;
    logic [7:0] hdr_q [RX_HDR_BYTES];
    logic [7:0] hdr_d [RX_HDR_BYTES];
    logic [7:0] pay_q [RX_PAY_BYTES];
    logic [7:0] pay_d [RX_PAY_BYTES];
    logic ok_q, ok_d, bad_q, bad_d;
    logic [15:0] len;

    assign len = {hdr_q[4], hdr_q[5]};

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        fcc_d = fcc_q;
        hdr_d = hdr_q;
        pay_d = pay_q;
        ok_d = 1'b0;
        bad_d = 1'b0;
        if (rx_valid) begin
            case (st_q)
                R_IDLE: begin
                    if (rx_data == START_BYTE) begin
                        st_d = R_HDR;
                        cnt_d = '0;
                        fcc_d = FCC_INIT;
                    end
                end
                R_HDR: begin
                    hdr_d[cnt_q[2:0]] = rx_data;
                    fcc_d = mah_fcc_step(fcc_q, rx_data);
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_q == RX_HDR_LAST) begin
                        cnt_d = '0;
                        st_d = ({hdr_q[4], rx_data} == '0) ? R_FCC : R_PAY;
                    end
                end
                R_PAY: begin
                    if (cnt_q < RX_PAY_KEEP) begin
                        pay_d[cnt_q[2:0]] = rx_data;
                    end
                    fcc_d = mah_fcc_step(fcc_q, rx_data);
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_d == len) begin
                        st_d = R_FCC;
                    end
                end
                R_FCC: begin
                    st_d = R_IDLE;
                    // Failed check drops the frame
                    if (rx_data == fcc_q && {hdr_q[0], hdr_q[1]} == FRAME_TYPE) begin
                        ok_d = 1'b1;
                    end else begin
                        bad_d = 1'b1;
                    end
                end
                default: st_d = R_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_q <= R_IDLE;
            cnt_q <= '0;
            fcc_q <= FCC_INIT;
            ok_q <= 1'b0;
            bad_q <= 1'b0;
            for (int i = 0; i < RX_HDR_BYTES; i++) hdr_q[i] <= 8'h00;
            for (int i = 0; i < RX_PAY_BYTES; i++) pay_q[i] <= 8'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            fcc_q <= fcc_d;
            ok_q <= ok_d;
            bad_q <= bad_d;
            hdr_q <= hdr_d;
            pay_q <= pay_d;
        end
    end

    assign fr.frame_ok = ok_q;
    assign fr.frame_bad = bad_q;
    assign fr.frame_type = {hdr_q[0], hdr_q[1]};
    assign fr.command_code = hdr_q[2];
    assign fr.function_byte = hdr_q[3];
    assign fr.payload_length = len;
    assign fr.result = {pay_q[0], pay_q[1]};
    assign fr.obj_count = pay_q[2];
    assign fr.obj_num = pay_q[3];
    assign fr.obj_total = pay_q[4];

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    property p_ok_needs_check;
        ok_q |-> $past(rx_valid && st_q == R_FCC && rx_data == fcc_q);
    endproperty
    a_ok_needs_check: assert property (p_ok_needs_check) else $error("frame passed bad check");

    property p_bad_not_ok;
        (rx_valid && st_q == R_FCC && rx_data != fcc_q) |=> bad_q && !ok_q;
    endproperty
    a_bad_not_ok: assert property (p_bad_not_ok) else $error("bad frame not dropped");
endmodule // mah_rx_frame
`default_nettype wire

// [hdl/mah_init_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module mah_init_seq (
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    input wire logic have_objects,
    input wire logic all_info_ready,
    input wire logic inquiry_faulty,
    input wire logic node_profile_done,
    input wire logic construct_ok,
    input wire logic construct_fail,
    input wire logic [7:0] function_byte,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output var mah_pkg::mah_seq_t seq_state,
    output logic normal_op,
    output logic error_stop,
    output logic [7:0] object_id,
    output logic object_rsp
);
    import mah_pkg::*;

    mah_seq_t state_q, state_d;
    logic [3:0] idx_q, idx_d;
    logic [7:0] fcc_q, fcc_d, txd_q, txd_d, id_q, id_d, fn_q, fn_d;
    logic txv_q, txv_d, faulty_q, faulty_d, fail_q, fail_d, np_q, np_d;
    logic normal_q, err_q, rsp_q, rsp_d;
    logic [7:0] cmd, p0, p1;
    logic [15:0] len, res;
    logic sending, taken, last, done, echo;
    logic rsp_cpl, rsp_start, rsp_inq, inq_good;

    mah_rx_if rxi ();

    mah_rx_frame u_rx (
        .clock(clock),
        .reset(reset),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .fr(rxi.rx)
    );

    function automatic logic [7:0] frame_byte(input logic [3:0] i, input logic lst,
        input logic [7:0] c, input logic [7:0] f, input logic [15:0] l,
        input logic [7:0] a, input logic [7:0] b, input logic [7:0] k);
        if (lst) return k;
        case (i)
            TX_IDX_STX: return START_BYTE;
            TX_IDX_FT_HI: return FRAME_TYPE[15:8];
            TX_IDX_FT_LO: return FRAME_TYPE[7:0];
            TX_IDX_CN: return c;
            TX_IDX_FN: return f;
            TX_IDX_DL_HI: return l[15:8];
            TX_IDX_DL_LO: return l[7:0];
            TX_IDX_PAY0: return a;
            default: return b;
        endcase
    endfunction

    // Frame contents per sending state
    assign res = (state_q == S_START_SEND) ? (fail_q ? RES_INVALID : RES_OK)
        : (faulty_q ? RES_INVALID : RES_OK);
    assign cmd = (state_q == S_INQ_SEND) ? CMD_INQ
        : (state_q == S_START_SEND) ? CMD_START : CMD_CPL;
    assign len = (state_q == S_INQ_SEND) ? LEN_OBJ_ID : LEN_RESULT;
    assign p0 = (state_q == S_INQ_SEND) ? id_q : res[15:8];
    assign p1 = res[7:0];

    assign sending = state_q == S_INQ_SEND || state_q == S_CPL_SEND
        || state_q == S_START_SEND;
    assign taken = txv_q && tx_ready;
    assign last = idx_q == 4'(TX_IDX_PAY0 + len[3:0]);
    assign done = taken && last;

    // Answer must echo function byte or report it unimplemented
    assign echo = rxi.frame_ok
        && (rxi.function_byte == fn_q || rxi.function_byte == FN_NOT_IMPL);
    assign rsp_cpl = echo && rxi.command_code == RSP_CPL;
    assign rsp_start = echo && rxi.command_code == RSP_START;
    assign rsp_inq = echo && rxi.command_code == RSP_INQ;
    // Sanity of per-object answer; fixed-size maps give a fixed minimum
    assign inq_good = (rxi.result == RES_OK || rxi.result == RES_NET_DOWN)
        && rxi.obj_count == OBJ_COUNT_ONE
        && rxi.obj_num == id_q && rxi.obj_total >= id_q
        && rxi.payload_length >= RSP_INQ_MIN_LEN;

    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        fcc_d = fcc_q;
        txd_d = txd_q;
        txv_d = txv_q;
        id_d = id_q;
        fn_d = fn_q;
        faulty_d = faulty_q;
        fail_d = fail_q;
        np_d = np_q | node_profile_done;
        rsp_d = 1'b0;
        if (sending) begin
            if (!txv_q) begin
                txv_d = 1'b1;
                txd_d = frame_byte(idx_q, last, cmd, fn_q, len, p0, p1, fcc_q);
            end else if (taken) begin
                txv_d = 1'b0;
                idx_d = idx_q + 4'h1;
                if (idx_q != TX_IDX_STX) begin
                    fcc_d = mah_fcc_step(fcc_q, txd_q);
                end
                if (last) begin
                    idx_d = TX_IDX_STX;
                    fcc_d = FCC_INIT;
                end
            end
            if (!txv_q && idx_q == TX_IDX_STX) begin
                fn_d = function_byte;
            end
        end
        if (state_q != S_CPL_SEND && inquiry_faulty) begin
            faulty_d = 1'b1;
        end
        case (state_q)
            S_IDLE, S_ERROR: begin
                if (start) begin
                    faulty_d = 1'b0;
                    fail_d = 1'b0;
                    np_d = node_profile_done;
                    id_d = FIRST_OBJ_ID;
                    // Per-object exchange when no object is held inside
                    state_d = have_objects ? S_WAIT_INFO : S_INQ_SEND;
                end
            end
            S_INQ_SEND: if (done) state_d = S_INQ_WAIT;
            S_INQ_WAIT: begin
                if (rsp_inq) begin
                    rsp_d = inq_good;
                    if (!inq_good) begin
                        faulty_d = 1'b1;
                        state_d = S_CPL_SEND;
                    end else if (id_q == rxi.obj_total) begin
                        state_d = S_CPL_SEND;
                    end else begin
                        id_d = id_q + 8'h01;
                        state_d = S_INQ_SEND;
                    end
                end
            end
            S_WAIT_INFO: if (all_info_ready || faulty_q) state_d = S_CPL_SEND;
            S_CPL_SEND: if (done) state_d = faulty_q ? S_ERROR : S_CPL_WAIT;
            S_CPL_WAIT: begin
                if (rsp_cpl) begin
                    state_d = (rxi.result == RES_OK) ? S_BUILD : S_ERROR;
                end
            end
            S_BUILD: begin
                if (np_q && construct_fail) begin
                    fail_d = 1'b1;
                    state_d = S_START_SEND;
                end else if (np_q && construct_ok) begin
                    state_d = S_START_SEND;
                end
            end
            S_START_SEND: if (done) state_d = fail_q ? S_ERROR : S_START_WAIT;
            S_START_WAIT: begin
                if (rsp_start) begin
                    state_d = (rxi.result == RES_OK) ? S_NORMAL : S_ERROR;
                end
            end
            S_NORMAL: state_d = S_NORMAL;
            default: state_d = S_ERROR;
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= S_IDLE;
            idx_q <= TX_IDX_STX;
            fcc_q <= FCC_INIT;
            txd_q <= 8'h00;
            txv_q <= 1'b0;
            id_q <= FIRST_OBJ_ID;
            fn_q <= FN_NOT_IMPL;
            faulty_q <= 1'b0;
            fail_q <= 1'b0;
            np_q <= 1'b0;
            normal_q <= 1'b0;
            err_q <= 1'b0;
            rsp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            fcc_q <= fcc_d;
            txd_q <= txd_d;
            txv_q <= txv_d;
            id_q <= id_d;
            fn_q <= fn_d;
            faulty_q <= faulty_d;
            fail_q <= fail_d;
            np_q <= np_d;
            normal_q <= state_d == S_NORMAL;
            err_q <= state_d == S_ERROR;
            rsp_q <= rsp_d;
        end
    end

    assign tx_data = txd_q;
    assign tx_valid = txv_q;
    assign seq_state = state_q;
    assign normal_op = normal_q;
    assign error_stop = err_q;
    assign object_id = id_q;
    assign object_rsp = rsp_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_cpl_bad_sent;
        state_q == S_CPL_SEND && done && faulty_q;
    endsequence
    sequence s_start_fail_sent;
        state_q == S_START_SEND && done && fail_q;
    endsequence

    property p_cpl_info;
        (state_q == S_CPL_SEND && $past(state_q) == S_WAIT_INFO)
            |-> $past(all_info_ready || faulty_q);
    endproperty
    a_cpl_info: assert property (p_cpl_info) else $error("completion before info");

    property p_cpl_bad_stop;
        s_cpl_bad_sent |=> state_q == S_ERROR ##1 err_q;
    endproperty
    a_cpl_bad_stop: assert property (p_cpl_bad_stop) else $error("invalid did not stop");

    property p_stx;
        (txv_q && idx_q == TX_IDX_STX) |-> txd_q == START_BYTE;
    endproperty
    a_stx: assert property (p_stx) else $error("frame start byte wrong");

    property p_cpl_cmd;
        (state_q == S_CPL_SEND && txv_q && idx_q == TX_IDX_CN) |-> txd_q == CMD_CPL;
    endproperty
    a_cpl_cmd: assert property (p_cpl_cmd) else $error("completion code wrong");

    property p_start_np;
        state_q == S_START_SEND |-> np_q;
    endproperty
    a_start_np: assert property (p_start_np) else $error("startup before node profile");

    property p_start_ok;
        ($rose(state_q == S_START_SEND) && !fail_q) |-> $past(construct_ok);
    endproperty
    a_start_ok: assert property (p_start_ok) else $error("startup without construction");

    property p_start_fail;
        s_start_fail_sent |=> state_q == S_ERROR;
    endproperty
    a_start_fail: assert property (p_start_fail) else $error("failed startup not stopped");

    property p_normal;
        (state_q == S_START_WAIT && rsp_start && rxi.result == RES_OK) |=> normal_q;
    endproperty
    a_normal: assert property (p_normal) else $error("normal operation not entered");

    property p_first_id;
        (state_q == S_IDLE && start && !have_objects) |=> state_q == S_INQ_SEND
            && id_q == FIRST_OBJ_ID;
    endproperty
    a_first_id: assert property (p_first_id) else $error("first object id wrong");

    property p_next_id;
        (state_q == S_INQ_WAIT && rsp_inq && inq_good && id_q != rxi.obj_total)
            |=> state_q == S_INQ_SEND && id_q == $past(id_q) + 8'h01;
    endproperty
    a_next_id: assert property (p_next_id) else $error("object id not sequential");

    property p_inq_cmd;
        (state_q == S_INQ_SEND && txv_q && idx_q == TX_IDX_CN) |-> txd_q == CMD_INQ;
    endproperty
    a_inq_cmd: assert property (p_inq_cmd) else $error("inquiry code wrong");
endmodule // mah_init_seq
`default_nettype wire

// [bench/mah_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mah_host_model (
    input wire logic clock,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic [15:0] cpl_ack,
    input wire logic [15:0] st_ack,
    input wire logic [15:0] obj_res,
    input wire logic [7:0] total,
    input wire logic fn_zero,
    input wire logic [1:0] decoy,
    output logic busy
);
    import mah_pkg::*;
    logic [7:0] q[$];
    logic [32:0] log[$];
    logic [7:0] s;
    logic [15:0] pay;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h5a;
        busy = 1'b0;
    end
    // Decoy kinds: 1 bad check byte, 2 wrong function byte, 3 wrong frame type
    task automatic send(input logic [7:0] c, input logic [7:0] f, input logic [1:0] k,
            input logic [15:0] res, input logic [7:0] id);
        logic [7:0] r[$];
        logic [7:0] x;
        r = {START_BYTE, 8'h00, (k == 2'h3) ? 8'h03 : 8'h02, c, (k == 2'h2) ? ~f : f};
        if (c == RSP_INQ) begin
            r = {r, 8'h00, 8'hcc, res[15:8], res[7:0], OBJ_COUNT_ONE, id, total};
            r = {r, 8'h05, 8'hff, 8'h01, 8'h00, 8'hc2};
            repeat (194) r.push_back(8'($urandom));
        end else begin
            r = {r, LEN_RESULT[15:8], LEN_RESULT[7:0], res[15:8], res[7:0]};
        end
        x = 8'h00;
        for (int i = 1; i < r.size(); i++) x ^= r[i];
        r.push_back((k == 2'h1) ? ~x : x);
        foreach (r[i]) begin
            rx_data <= r[i];
            rx_valid <= 1'b1;
            @(posedge clock);
            if ($urandom_range(3) == 0) begin
                rx_valid <= 1'b0;
                rx_data <= ~r[i];
                @(posedge clock);
            end
        end
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        // Idle edge keeps back-to-back frames from re-driving in one step
        @(posedge clock);
    endtask
    always @(posedge clock) begin
        tx_ready <= ($urandom_range(2) != 0);
        if (tx_valid && tx_ready) begin
            q.push_back(tx_data);
            if (q.size() > 7 && q.size() == 32'({q[5], q[6]}) + 8) begin
                s = 8'h00;
                for (int i = 1; i < q.size() - 1; i++) s ^= q[i];
                pay = (q.size() == 10) ? {q[7], q[8]} : {8'h00, q[7]};
                log.push_back({q[0] == START_BYTE && {q[1], q[2]} == FRAME_TYPE
                    && s == q[q.size() - 1], q[3], q[4], pay});
                busy <= 1'b1;
                if (decoy != 2'h0) send(q[3] | 8'h80, q[4], decoy, 16'hffff, q[7]);
                send(q[3] | 8'h80, fn_zero ? FN_NOT_IMPL : q[4], 2'h0,
                    (q[3] == CMD_CPL) ? cpl_ack : (q[3] == CMD_START) ? st_ack : obj_res,
                    q[7]);
                busy <= 1'b0;
                q.delete();
            end
        end
    end
endmodule // mah_host_model
`default_nettype wire

// [bench/adapter_init_command_handshake_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module adapter_init_command_handshake_tb;
    import mah_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic have_objects = 1'b0, all_info_ready = 1'b0, inquiry_faulty = 1'b0;
    logic node_profile_done = 1'b0, construct_ok = 1'b0, construct_fail = 1'b0;
    logic [7:0] function_byte = 8'h11;
    logic [7:0] rx_data, tx_data, object_id;
    logic rx_valid, tx_ready, tx_valid, normal_op, error_stop, object_rsp, busy;
    mah_seq_t seq_state;
    logic [15:0] cpl_ack = 16'h0000, st_ack = 16'h0000, obj_res = 16'h0000;
    logic [7:0] total = 8'h01;
    logic fn_zero = 1'b0;
    logic [1:0] decoy = 2'h0;
    int error_cnt = 0;
    int tests_run = 0;
    int rsp_cnt = 0;
    logic [15:0] codes[8] = '{16'h0000, 16'h0001, 16'h0011, 16'h0012,
        16'h0101, 16'h0103, 16'h0105, 16'hffff};
    mah_init_seq i_dut (.clock(clock), .reset(reset), .start(start),
        .have_objects(have_objects), .all_info_ready(all_info_ready),
        .inquiry_faulty(inquiry_faulty), .node_profile_done(node_profile_done),
        .construct_ok(construct_ok), .construct_fail(construct_fail),
        .function_byte(function_byte), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .seq_state(seq_state),
        .normal_op(normal_op), .error_stop(error_stop), .object_id(object_id),
        .object_rsp(object_rsp));
    mah_host_model i_host (.clock(clock), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .cpl_ack(cpl_ack),
        .st_ack(st_ack), .obj_res(obj_res), .total(total), .fn_zero(fn_zero),
        .decoy(decoy), .busy(busy));
    always #5 clock = ~clock;
    always @(posedge clock) if (object_rsp === 1'b1) rsp_cnt++;
    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Expected log entry: check passed, command, function byte, payload
    function automatic logic [32:0] frame_exp(input logic [7:0] c, input logic [7:0] f,
            input logic [15:0] p);
        return {1'b1, c, f, p};
    endfunction
    task automatic close_out;
        $display("Checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic run(input logic hv, input logic flt, input logic cf, input logic [15:0] orr,
            input logic [15:0] ca, input logic [15:0] sa, input logic [7:0] tot,
            input logic [1:0] dk);
        logic [32:0] exp[$];
        logic bad;
        logic obad;
        logic fin;
        int n;
        @(posedge clock);
        {cpl_ack, st_ack, obj_res, total, decoy} <= {ca, sa, orr, tot, dk};
        function_byte <= 8'($urandom_range(254, 1));
        fn_zero <= 1'($urandom_range(1));
        {have_objects, inquiry_faulty, construct_ok, construct_fail} <= {hv, flt, !cf, cf};
        {all_info_ready, node_profile_done} <= 2'b00;
        // Restart from error stop without reset
        reset <= (error_stop !== 1'b1);
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        obad = 1'b0;
        for (int i = 1; !hv && i <= total && !obad; i++) begin
            exp.push_back(frame_exp(CMD_INQ, function_byte, 16'(i)));
            obad = !(orr inside {RES_OK, RES_NET_DOWN});
        end
        // Faulty inquiry data spoils the completion on either path
        bad = obad || flt;
        exp.push_back(frame_exp(CMD_CPL, function_byte, bad ? RES_INVALID : RES_OK));
        n = exp.size();
        if (!bad && ca == RES_OK) exp.push_back(frame_exp(CMD_START, function_byte,
            cf ? RES_INVALID : RES_OK));
        fin = !bad && ca == RES_OK && !cf && sa == RES_OK;
        i_host.log.delete();
        rsp_cnt = 0;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        repeat (60) @(posedge clock);
        if (hv && !flt) chk("early frames", 0, i_host.log.size());
        all_info_ready <= 1'b1;
        for (int t = 0; t < 20000 && i_host.log.size() < n; t++) @(posedge clock);
        repeat (100) @(posedge clock);
        chk("frames before profile", n, i_host.log.size());
        node_profile_done <= 1'b1;
        for (int t = 0; t < 20000 && (busy || !(normal_op || error_stop)); t++)
            @(posedge clock);
        repeat (50) @(posedge clock);
        chk("frame count", exp.size(), i_host.log.size());
        foreach (exp[i]) if (i < i_host.log.size()) chk("frame", exp[i], i_host.log[i]);
        chk("normal", fin, normal_op);
        chk("error", !fin, error_stop);
        chk("state", fin ? S_NORMAL : S_ERROR, seq_state);
        chk("object answers", (!hv && !obad) ? total : 8'h00, rsp_cnt);
        if (!hv) chk("object id", obad ? FIRST_OBJ_ID : total, object_id);
    endtask
    initial begin
        void'($urandom(82));
        run(1'b0, 1'b0, 1'b0, RES_OK, RES_OK, RES_OK, 8'h04, 2'h1);
        run(1'b1, 1'b0, 1'b0, RES_OK, RES_OK, RES_OK, 8'h01, 2'h2);
        run(1'b1, 1'b1, 1'b0, RES_OK, RES_OK, RES_OK, 8'h01, 2'h3);
        run(1'b1, 1'b0, 1'b0, RES_OK, 16'hffff, RES_OK, 8'h01, 2'h0);
        run(1'b1, 1'b0, 1'b1, RES_OK, RES_OK, RES_OK, 8'h01, 2'h1);
        run(1'b1, 1'b0, 1'b0, RES_OK, RES_OK, 16'hffff, 8'h01, 2'h0);
        foreach (codes[i]) run(1'b0, 1'b0, 1'($urandom_range(1)), codes[i], RES_OK, RES_OK,
            8'($urandom_range(4, 1)), 2'($urandom_range(3)));
        repeat (4) run(1'($urandom_range(1)), 1'($urandom_range(1)), 1'($urandom_range(1)),
            codes[$urandom_range(1)], RES_OK, RES_OK, 8'($urandom_range(4, 1)),
            2'($urandom_range(3)));
        close_out();
    end
    initial begin
        #800000;
        error_cnt++;
        close_out();
    end
endmodule // adapter_init_command_handshake_tb
`default_nettype wire
